// ### rtl/ifd_decode.sv
// ifd_decode: fetches 12-bit instruction words, resolves their format,
// extracts operand fields and sequences one- or two-cycle execution.
// assumes program memory presents instr_word with instr_valid steady
// from the start of an instruction cycle; branch_taken and
// changes_pc come from the core in the same clock domain.
//
// Operation
// - destination bit 0 writes accumulator, 1 writes the file register
// - don't-care word bits never alter decode results
// - one instruction cycle, two when test true or counter altered
// - an instruction cycle spans four oscillator periods
// - byte format: opcode 11:6, destination 5, file address 4:0
// - bit format: opcode 11:8, bit number 7:5, file 4:0
// - bit number picks one bit of the 8-bit file register
// - literal format: opcode 11:8, 8-bit literal 7:0
// - long jump: opcode 11:9, 9-bit target 8:0
// - each instruction is one 12-bit word of opcode plus operands
`timescale 1ns/1ps
module ifd_decode
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [11:0] instr_word,
	input wire logic instr_valid,
	input wire logic branch_taken,
	input wire logic changes_pc,
	output logic fetch_strobe,
	output logic [1:0] phase,
	output logic cycle_end,
	output ifd_pkg::ifd_fmt_t fmt,
	output logic [5:0] opcode,
	output logic dest_file,
	output logic acc_write,
	output logic file_write,
	output logic [4:0] file_addr,
	output logic [2:0] bit_num,
	output logic [7:0] bit_mask,
	output logic [7:0] literal,
	output logic [8:0] jump_target,
	output logic decode_valid,
	output logic flush_cycle,
	output logic instr_done
);
	logic rst_s1_q;
	logic rst_s2_q;
	logic srst_n;

	// reset enters asynchronously, released through two flops
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign srst_n = rst_s2_q;

	logic [1:0] ph;
	logic ph_end;

	ifd_phase u_phase
	(
		.clock(clock),
		.rst_n(srst_n),
		.phase(ph),
		.cycle_end(ph_end)
	);

	function automatic ifd_pkg::ifd_fmt_t fmt_of(input logic [11:0] w);
		ifd_pkg::ifd_fmt_t f;
		f = ifd_pkg::IFD_FMT_LIT;
		if (w[11:10] == ifd_pkg::TOP_BYTE)
			f = ifd_pkg::IFD_FMT_BYTE;
		else if (w[11:10] == ifd_pkg::TOP_BIT)
			f = ifd_pkg::IFD_FMT_BIT;
		else if (w[ifd_pkg::JMP_OP_HI:ifd_pkg::JMP_OP_LO] ==
			ifd_pkg::JMP_OPCODE)
			f = ifd_pkg::IFD_FMT_JMP;
		return f;
	endfunction

	typedef enum logic [1:0] {
		IFD_ST_FETCH,
		IFD_ST_EXEC,
		IFD_ST_FLUSH
	} ifd_state_t;

	ifd_state_t st_q;
	ifd_state_t st_d;
	ifd_pkg::ifd_fmt_t fmt_q;
	ifd_pkg::ifd_fmt_t fmt_d;
	logic [5:0] opc_q;
	logic [5:0] opc_d;
	logic dest_q;
	logic dest_d;
	logic [4:0] file_q;
	logic [4:0] file_d;
	logic [2:0] bitn_q;
	logic [2:0] bitn_d;
	logic [7:0] mask_q;
	logic [7:0] mask_d;
	logic [7:0] lit_q;
	logic [7:0] lit_d;
	logic [8:0] jmp_q;
	logic [8:0] jmp_d;
	logic done_q;
	logic done_d;
	logic take;
	ifd_pkg::ifd_fmt_t wf;

	// words are taken only at the first period of an instruction cycle
	assign take = (ph == ifd_pkg::RESET_PHASE) && instr_valid &&
		(st_q == ifd_state_t'(IFD_ST_FETCH) || (st_q == IFD_ST_EXEC));
	assign wf = fmt_of(instr_word);

	genvar gi;
	generate
		for (gi = 0; gi < ifd_pkg::DATA_W; gi++)
		begin : g_mask
			// only the bit format owns a mask; in the other formats
			// bits 7:5 belong to other fields and must not leak out
			assign mask_d[gi] = take ? (wf == ifd_pkg::IFD_FMT_BIT &&
				instr_word[ifd_pkg::BITN_HI:ifd_pkg::BITN_LO] == 3'(gi))
				: mask_q[gi];
		end
	endgenerate

	always_comb
	begin
		st_d = st_q;
		fmt_d = fmt_q;
		opc_d = opc_q;
		dest_d = dest_q;
		file_d = file_q;
		bitn_d = bitn_q;
		lit_d = lit_q;
		jmp_d = jmp_q;
		done_d = 1'b0;
		if (take)
		begin
			st_d = IFD_ST_EXEC;
			fmt_d = wf;
			opc_d = 6'h00;
			dest_d = ifd_pkg::DEST_ACC;
			file_d = 5'h00;
			bitn_d = 3'h0;
			lit_d = 8'h00;
			jmp_d = 9'h000;
			// fields outside a format stay zero, so don't-care bits
			// never reach the outputs
			unique case (wf)
				ifd_pkg::IFD_FMT_BYTE:
				begin
					opc_d = instr_word[ifd_pkg::BYTE_OP_HI:
						ifd_pkg::BYTE_OP_LO];
					dest_d = instr_word[ifd_pkg::BYTE_DEST_POS];
					file_d = instr_word[ifd_pkg::FILE_HI:
						ifd_pkg::FILE_LO];
				end
				ifd_pkg::IFD_FMT_BIT:
				begin
					opc_d = {2'h0, instr_word[ifd_pkg::NIB_OP_HI:
						ifd_pkg::NIB_OP_LO]};
					bitn_d = instr_word[ifd_pkg::BITN_HI:
						ifd_pkg::BITN_LO];
					file_d = instr_word[ifd_pkg::FILE_HI:
						ifd_pkg::FILE_LO];
				end
				ifd_pkg::IFD_FMT_LIT:
				begin
					opc_d = {2'h0, instr_word[ifd_pkg::NIB_OP_HI:
						ifd_pkg::NIB_OP_LO]};
					lit_d = instr_word[ifd_pkg::LIT_HI:
						ifd_pkg::LIT_LO];
				end
				ifd_pkg::IFD_FMT_JMP:
				begin
					opc_d = {3'h0, instr_word[ifd_pkg::JMP_OP_HI:
						ifd_pkg::JMP_OP_LO]};
					jmp_d = instr_word[ifd_pkg::JMP_HI:
						ifd_pkg::JMP_LO];
				end
			endcase
		end
		else if (ph_end)
		begin
			unique case (st_q)
				IFD_ST_FETCH:
					st_d = IFD_ST_FETCH;
				IFD_ST_EXEC:
				begin
					// a jump always changes the counter
					if (branch_taken || changes_pc ||
						fmt_q == ifd_pkg::IFD_FMT_JMP)
						st_d = IFD_ST_FLUSH;
					else
					begin
						st_d = IFD_ST_FETCH;
						done_d = 1'b1;
					end
				end
				IFD_ST_FLUSH:
				begin
					st_d = IFD_ST_FETCH;
					done_d = 1'b1;
				end
				// the fourth code is unused; fall back to fetching
				default:
					st_d = IFD_ST_FETCH;
			endcase
		end
	end

	always_ff @(posedge clock or negedge srst_n)
	begin
		if (!srst_n)
		begin
			st_q <= IFD_ST_FETCH;
			fmt_q <= ifd_pkg::IFD_FMT_BYTE;
			opc_q <= 6'h00;
			dest_q <= ifd_pkg::DEST_ACC;
			file_q <= 5'h00;
			bitn_q <= 3'h0;
			mask_q <= 8'h00;
			lit_q <= 8'h00;
			jmp_q <= 9'h000;
			done_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			fmt_q <= fmt_d;
			opc_q <= opc_d;
			dest_q <= dest_d;
			file_q <= file_d;
			bitn_q <= bitn_d;
			mask_q <= mask_d;
			lit_q <= lit_d;
			jmp_q <= jmp_d;
			done_q <= done_d;
		end
	end

	// a flushed second cycle fetches nothing new
	assign fetch_strobe = (ph == ifd_pkg::RESET_PHASE) &&
		(st_q != IFD_ST_FLUSH);
	assign phase = ph;
	assign cycle_end = ph_end;
	assign fmt = fmt_q;
	assign opcode = opc_q;
	assign dest_file = dest_q;
	assign decode_valid = (st_q == IFD_ST_EXEC);
	assign acc_write = decode_valid && fmt_q == ifd_pkg::IFD_FMT_BYTE &&
		dest_q == ifd_pkg::DEST_ACC;
	assign file_write = decode_valid && fmt_q == ifd_pkg::IFD_FMT_BYTE &&
		dest_q == ifd_pkg::DEST_FILE;
	assign file_addr = file_q;
	assign bit_num = bitn_q;
	assign bit_mask = mask_q;
	assign literal = lit_q;
	assign jump_target = jmp_q;
	assign flush_cycle = (st_q == IFD_ST_FLUSH);
	assign instr_done = done_q;
endmodule

// ### pkg/ifd_pkg.sv
// ifd_pkg: field layout, format and timing constants for the 12-bit
// instruction decoder; shared by the decoder top and its phase counter.
package ifd_pkg;
	localparam int WORD_W = 12;
	localparam int FILE_W = 5;
	localparam int BITN_W = 3;
	localparam int LIT_W = 8;
	localparam int JMP_W = 9;
	localparam int DATA_W = 8;
	// byte-oriented layout
	localparam int BYTE_OP_HI = 11;
	localparam int BYTE_OP_LO = 6;
	localparam int BYTE_DEST_POS = 5;
	// bit-oriented and literal layout
	localparam int NIB_OP_HI = 11;
	localparam int NIB_OP_LO = 8;
	localparam int BITN_HI = 7;
	localparam int BITN_LO = 5;
	localparam int FILE_HI = 4;
	localparam int FILE_LO = 0;
	localparam int LIT_HI = 7;
	localparam int LIT_LO = 0;
	// long jump layout
	localparam int JMP_OP_HI = 11;
	localparam int JMP_OP_LO = 9;
	localparam int JMP_HI = 8;
	localparam int JMP_LO = 0;
	// format selection from the top opcode bits
	localparam logic [1:0] TOP_BYTE = 2'h0;
	localparam logic [1:0] TOP_BIT = 2'h1;
	localparam logic [2:0] JMP_OPCODE = 3'h5;
	// timing and destination codes
	localparam int OSC_PER_CYCLE = 4;
	localparam int PHASE_W = 2;
	localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_CYCLE - 1);
	localparam logic [1:0] RESET_PHASE = 2'h0;
	localparam logic DEST_ACC = 1'h0;
	localparam logic DEST_FILE = 1'h1;
	typedef enum logic [1:0] {
		IFD_FMT_BYTE,
		IFD_FMT_BIT,
		IFD_FMT_LIT,
		IFD_FMT_JMP
	} ifd_fmt_t;
endpackage

// ### rtl/ifd_phase.sv
// ifd_phase: divides the oscillator clock into four-period instruction
// cycles. assumes a synchronised active-low reset from the top.
`timescale 1ns/1ps
module ifd_phase
(
	input wire logic clock,
	input wire logic rst_n,
	output logic [1:0] phase,
	output logic cycle_end
);
	logic [1:0] phase_q;
	logic [1:0] phase_d;

	always_comb
	begin
		if (phase_q == ifd_pkg::PHASE_LAST)
			phase_d = ifd_pkg::RESET_PHASE;
		else
			phase_d = phase_q + 2'h1;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			phase_q <= ifd_pkg::RESET_PHASE;
		else
			phase_q <= phase_d;
	end

	assign phase = phase_q;
	assign cycle_end = (phase_q == ifd_pkg::PHASE_LAST);
endmodule

// ### tb/ifd_decode_assertions.sv
// ifd_decode_chk: timing and field checks on the decoder ports.
// assumes binding to ifd_decode and a sane program memory.
`timescale 1ns/1ps
module ifd_decode_chk
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [11:0] instr_word,
	input wire logic instr_valid,
	input wire logic branch_taken,
	input wire logic changes_pc,
	input wire logic fetch_strobe,
	input wire logic [1:0] phase,
	input wire logic cycle_end,
	input wire ifd_pkg::ifd_fmt_t fmt,
	input wire logic [5:0] opcode,
	input wire logic dest_file,
	input wire logic acc_write,
	input wire logic file_write,
	input wire logic [4:0] file_addr,
	input wire logic [2:0] bit_num,
	input wire logic [7:0] bit_mask,
	input wire logic [7:0] literal,
	input wire logic [8:0] jump_target,
	input wire logic decode_valid,
	input wire logic flush_cycle,
	input wire logic instr_done
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire logic tk = fetch_strobe && instr_valid;
	wire logic end1 = decode_valid && cycle_end && !flush_cycle;
	a_phase_step: assert property (
		phase != 2'h0 |=> phase == $past(phase) + 2'h1) else $error("bad phase");
	a_byte_fields: assert property (
		tk && instr_word[11:10] == 2'h0 |=> fmt == 2'h0
		&& {opcode, dest_file, file_addr} == $past(instr_word)) else $error("byte");
	a_bit_fields: assert property (
		tk && instr_word[11:10] == 2'h1 |=> {bit_num, file_addr}
		== $past(instr_word[7:0]) && bit_mask == 8'h01 << bit_num
		&& opcode == {2'h0, $past(instr_word[11:8])}) else $error("bit");
	a_lit_fields: assert property (
		tk && instr_word[11] && instr_word[11:9] != 3'h5 |=> fmt == 2'h2
		&& literal == $past(instr_word[7:0]) && jump_target == 9'h000)
		else $error("literal");
	a_jump_fields: assert property (
		tk && instr_word[11:9] == 3'h5 |=> fmt == 2'h3
		&& jump_target == $past(instr_word[8:0])) else $error("jump");
	a_dest_write: assert property (
		decode_valid && fmt == 2'h0 |-> file_write == dest_file
		&& acc_write == !dest_file) else $error("dest");
	a_one_cycle: assert property (
		end1 && !branch_taken && !changes_pc && fmt != 2'h3
		|=> instr_done && !flush_cycle) else $error("one cycle");
	a_two_cycle: assert property (
		end1 && (branch_taken || changes_pc || fmt == 2'h3)
		|=> (!instr_done && flush_cycle) [*4] ##1 instr_done)
		else $error("two cycle");
	a_fetch_gate: assert property (
		fetch_strobe == (phase == 2'h0 && !flush_cycle)) else $error("fetch");
	a_exec_span: assert property (
		tk |=> decode_valid [*3] ##1 !decode_valid) else $error("exec span");
	a_write_scope: assert property (
		!(decode_valid && fmt == 2'h0) |-> !acc_write && !file_write)
		else $error("write scope");
	a_end_phase: assert property (
		cycle_end == (phase == 2'h3)) else $error("cycle end");
endmodule

// ### tb/ifd_pmem.sv
// ifd_pmem: program memory model feeding words and core flags.
// assumes the bench fills mem before raising en.
`timescale 1ns/1ps
module ifd_pmem
(
	input wire logic clock,
	input wire logic en,
	input wire logic fetch_strobe,
	output logic [11:0] instr_word,
	output logic instr_valid,
	output logic branch_taken,
	output logic changes_pc
);
	logic [13:0] mem[$];
	int i = 0;
	initial
	begin
		instr_word = 12'h000;
		instr_valid = 1'b0;
		{changes_pc, branch_taken} = 2'h0;
	end
	always @(posedge clock)
	begin
		int n;
		n = i + int'(fetch_strobe && instr_valid);
		if (fetch_strobe && instr_valid)
			{changes_pc, branch_taken} <= mem[i][13:12];
		i <= n;
		instr_valid <= en && n < mem.size();
		// idle bus scrambles so a stale word never looks valid
		instr_word <= en && n < mem.size() ? mem[n][11:0] : ~instr_word;
	end
endmodule

// ### tb/tb_instr_format_decode.sv
// tb_instr_format_decode: random words through the decoder, fields
// and instruction spacing compared against notes in queues.
`timescale 1ns/1ps
module tb_instr_format_decode;
	logic clock, rst_n, en, instr_valid, branch_taken, changes_pc;
	logic tk = 1'b0;
	logic go = 1'b0;
	logic fetch_strobe, cycle_end, dest_file, acc_write, file_write;
	logic decode_valid, flush_cycle, instr_done;
	logic [11:0] instr_word, w;
	logic [1:0] phase, fl;
	ifd_pkg::ifd_fmt_t fmt;
	logic [5:0] opcode;
	logic [4:0] file_addr;
	logic [2:0] bit_num;
	logic [7:0] bit_mask, literal;
	logic [8:0] jump_target;
	logic [47:0] fq[$], e, got;
	int sq[$], fails = 0, comparisons = 0, cnt = 0, k;
	ifd_decode dut_u
	(
		.clock(clock),
		.rst_n(rst_n),
		.instr_word(instr_word),
		.instr_valid(instr_valid),
		.branch_taken(branch_taken),
		.changes_pc(changes_pc),
		.fetch_strobe(fetch_strobe),
		.phase(phase),
		.cycle_end(cycle_end),
		.fmt(fmt),
		.opcode(opcode),
		.dest_file(dest_file),
		.acc_write(acc_write),
		.file_write(file_write),
		.file_addr(file_addr),
		.bit_num(bit_num),
		.bit_mask(bit_mask),
		.literal(literal),
		.jump_target(jump_target),
		.decode_valid(decode_valid),
		.flush_cycle(flush_cycle),
		.instr_done(instr_done)
	);
	ifd_pmem pm_u
	(
		.clock(clock),
		.en(en),
		.fetch_strobe(fetch_strobe),
		.instr_word(instr_word),
		.instr_valid(instr_valid),
		.branch_taken(branch_taken),
		.changes_pc(changes_pc)
	);
	function automatic logic [47:0] ex(logic [11:0] w);
		logic [1:0] f;
		f = w[11:10] == 2'h0 ? 2'h0 : w[11:10] == 2'h1 ? 2'h1
			: w[11:9] == 3'h5 ? 2'h3 : 2'h2;
		case (f)
		2'h0: return {8'h0, w[11:6], w[5], w[4:0], 28'h0};
		2'h1: return {8'h1, 2'h0, w[11:8], 1'h0, w[4:0], w[7:5],
			8'h01 << w[7:5], 17'h0};
		2'h3: return {8'h3, 3'h0, w[11:9], 25'h0, w[8:0]};
		default: return {8'h2, 2'h0, w[11:8], 17'h0, w[7:0], 9'h0};
		endcase
	endfunction
	task chk(logic [47:0] g, logic [47:0] x);
		comparisons++;
		if (g !== x)
		begin
			fails++;
			$display("wrong value at %0t got %h exp %h", $time, g, x);
		end
	endtask
	task chk_gap(int g, int x);
		comparisons++;
		if (g != x)
		begin
			fails++;
			$display("wrong value at %0t got %h exp %h", $time, g, x);
		end
	endtask
	task final_report;
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		clock = 0;
		forever #50 clock = ~clock;
	end
	// sampled mid-cycle so every edge update has landed
	always @(negedge clock)
	begin
		cnt = cnt + 1;
		got = {6'h0, fmt, opcode, dest_file, file_addr, bit_num, bit_mask,
			literal, jump_target};
		if (tk)
			chk(got, fq.pop_front());
		tk = fetch_strobe === 1'b1 && instr_valid === 1'b1;
		if (tk && go)
			chk_gap(cnt, sq.pop_front());
		if (tk)
		begin
			go = 1;
			cnt = 0;
		end
	end
	initial
	begin
		rst_n = 0;
		en = 0;
		void'($urandom(10));
		for (k = 0; k < 60; k++)
		begin
			w = k == 0 ? 12'h0A5 : k == 1 ? 12'hA12 : 12'($urandom);
			fl = k[1] ? 2'($urandom) : 2'h0;
			e = ex(w);
			pm_u.mem.push_back({fl, w});
			fq.push_back(e);
			sq.push_back(fl != 2'h0 || e[41:40] == 2'h3 ? 8 : 4);
		end
		repeat (12) @(posedge clock);
		rst_n <= 1;
		repeat (3) @(posedge clock);
		en <= 1;
		for (k = 0; k < 2000 && fq.size() > 0; k++)
			@(posedge clock);
		if (fq.size() > 0)
			fails++;
		final_report;
	end
endmodule
bind ifd_decode ifd_decode_chk chk_u
(
	.clock(clock),
	.rst_n(rst_n),
	.instr_word(instr_word),
	.instr_valid(instr_valid),
	.branch_taken(branch_taken),
	.changes_pc(changes_pc),
	.fetch_strobe(fetch_strobe),
	.phase(phase),
	.cycle_end(cycle_end),
	.fmt(fmt),
	.opcode(opcode),
	.dest_file(dest_file),
	.acc_write(acc_write),
	.file_write(file_write),
	.file_addr(file_addr),
	.bit_num(bit_num),
	.bit_mask(bit_mask),
	.literal(literal),
	.jump_target(jump_target),
	.decode_valid(decode_valid),
	.flush_cycle(flush_cycle),
	.instr_done(instr_done)
);
